// ---- src/apw_engine.sv ----
// ata pio sector-write engine: task file, status sequencing, media handshake
// assumes tf_* strobes are one-cycle pulses already synchronous to core_clk
//
// Behaviour
// - multiple write sets busy within 400 ns of accepting the opcode
// - multiple write interrupts once per block, not per sector
// - data request drops and is set again for every sector, not only at each block start
// - count is sectors; full blocks then a partial remainder block
// - multiple write aborts when no block count set or disabled
// - block count of one sector always supported; larger optional
// - error ends at failing sector; later blocks not transferred
// - interrupt whenever data request rises at a block start after the first
// - on error address is failing sector, count holds remaining
// - multiple write without erase skips the implied erase
// - single-sector writes take 1..256 sectors, zero meaning 256
// - write starts at addressed sector then walks consecutive sectors
// - accept sets busy, then data request with busy cleared
// - no interrupt before the first data transfer
// - between sectors busy then data request plus interrupt
// - after last sector busy until done, then clear and interrupt
// - on error address registers hold failing sector
// - sector write without erase uses normal protocol
// - lba built from head nibble, cylinder high, low, sector
// - each sector is 512 bytes over the data port
`timescale 1ns/1ps
`default_nettype none
`include "apw_map.svh"
module apw_engine #(
  parameter int unsigned MAX_BLOCK = 16
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                tf_wr,
  input  wire logic                tf_rd,
  input  wire logic [2:0]          tf_addr,
  input  wire logic [15:0]         tf_wdata,
  output logic      [7:0]          tf_rdata,
  input  wire logic [7:0]          block_count,
  input  wire logic                multi_enable,
  output apw_pkg::apw_media_req_t  media_req,
  output logic      [15:0]         media_wdata,
  output logic                     media_wvalid,
  input  wire logic                media_done,
  input  wire logic                media_fail,
  output logic                     intrq
);
  import apw_pkg::*;

  function automatic logic [27:0] lba_of(input apw_addr_t a);
    lba_of = {a.drvhead[3:0], a.cylhi, a.cyllo, a.secnum};
  endfunction

  function automatic apw_addr_t addr_next(input apw_addr_t a);
    logic [27:0] l;
    l = lba_of(a) + 28'd1;
    addr_next = a;
    if (a.drvhead[`APW_DH_LBA]) begin
      addr_next = {l[7:0], l[15:8], l[23:16], a.drvhead[7:4], l[27:24]};
    end else if (a.secnum == 8'd63) begin
      addr_next.secnum = 8'd1;
      if (a.drvhead[3:0] == 4'hF) begin
        addr_next.drvhead[3:0] = 4'h0;
        {addr_next.cylhi, addr_next.cyllo} = {a.cylhi, a.cyllo} + 16'd1;
      end else begin
        addr_next.drvhead[3:0] = a.drvhead[3:0] + 4'h1;
      end
    end else begin
      addr_next.secnum = a.secnum + 8'd1;
    end
  endfunction

  apw_state_t  st_q, st_d;
  apw_addr_t   addr_q, addr_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [8:0]  left_q, left_d;
  logic [8:0]  blk_q, blk_d;
  logic [8:0]  word_q, word_d;
  logic [5:0]  dly_q, dly_d;
  logic [7:0]  feat_q, feat_d;
  logic [7:0]  err_q, err_d;
  logic        bsy_q;
  logic        bsy_d;
  logic        drq_q;
  logic        drq_d;
  logic        errb_q;
  logic        errb_d;
  logic        irq_q;
  logic        irq_d;
  logic        multi_q;
  logic        multi_d;
  logic        erase_q;
  logic        erase_d;
  logic [15:0] wdata_q, wdata_d;
  logic        wv_q, wv_d;
  logic [8:0]  bc9;

  wire data_wr = tf_wr && tf_addr == `APW_OFS_DATA;
  wire cmd_wr  = tf_wr && tf_addr == `APW_OFS_CMD && !bsy_q;
  wire [7:0] op = tf_wdata[7:0];

  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    left_d = left_q;
    blk_d = blk_q;
    word_d = word_q;
    dly_d = dly_q;
    feat_d = feat_q;
    err_d = err_q;
    bsy_d = bsy_q;
    drq_d = drq_q;
    errb_d = errb_q;
    irq_d = irq_q;
    multi_d = multi_q;
    erase_d = erase_q;
    wdata_d = wdata_q;
    wv_d = 1'b0;
    bc9 = (block_count == 8'd0 || block_count > MAX_BLOCK[7:0]) ? 9'd1 : {1'b0, block_count};
    if (tf_rd && tf_addr == `APW_OFS_CMD) begin
      irq_d = 1'b0;
    end
    if (tf_wr && !bsy_q && !drq_q) begin
      unique case (tf_addr)
        `APW_OFS_FEATURE: feat_d = op;
        `APW_OFS_SECCNT:  cnt_d = op;
        `APW_OFS_SECNUM:  addr_d.secnum = op;
        `APW_OFS_CYLLO:   addr_d.cyllo = op;
        `APW_OFS_CYLHI:   addr_d.cylhi = op;
        `APW_OFS_DRVHEAD: addr_d.drvhead = op;
        default: ;
      endcase
    end
    unique case (st_q)
      APW_IDLE: if (cmd_wr) begin
        bsy_d = 1'b1;
        drq_d = 1'b0;
        errb_d = 1'b0;
        err_d = `APW_RST_BYTE;
        left_d = (cnt_q == 8'd0) ? 9'd256 : {1'b0, cnt_q};
        multi_d = (op == `APW_OP_WR_MUL || op == `APW_OP_WR_MUL_NE);
        erase_d = !(op == `APW_OP_WR_MUL_NE || op == `APW_OP_WR_SEC_NE);
        dly_d = 6'd0;
        if (op == `APW_OP_WR_SEC || op == `APW_OP_WR_SEC_RT || op == `APW_OP_WR_SEC_NE) begin
          st_d = APW_SETUP;
        end else if (multi_d && block_count != 8'd0 && multi_enable) begin
          st_d = APW_SETUP;
        end else begin
          err_d[`APW_ER_ABRT] = 1'b1;
          errb_d = 1'b1;
          st_d = APW_DONE;
        end
      end
      APW_SETUP: begin
        dly_d = dly_q + 6'd1;
        if (dly_q == 6'(`APW_BSY_CYC - 1)) begin
          bsy_d = 1'b0;
          drq_d = 1'b1;
          word_d = 9'd0;
          blk_d = multi_q ? ((left_q < bc9) ? left_q : bc9) : 9'd1;
          if (left_q != ((cnt_q == 8'd0) ? 9'd256 : {1'b0, cnt_q})) begin
            irq_d = 1'b1;
          end
          st_d = APW_XFER;
        end
      end
      APW_XFER: if (data_wr) begin
        wdata_d = tf_wdata;
        wv_d = 1'b1;
        word_d = word_q + 9'd1;
        if (word_q == 9'(`APW_WORDS_PER_SEC - 1)) begin
          bsy_d = 1'b1;
          drq_d = 1'b0;
          st_d = APW_PROG;
        end
      end
      APW_PROG: begin
        if (media_fail) begin
          err_d[`APW_ER_IDNF] = 1'b1;
          errb_d = 1'b1;
          st_d = APW_DONE;
        end else if (media_done) begin
          left_d = left_q - 9'd1;
          blk_d = blk_q - 9'd1;
          if (left_q != 9'd1) begin
            addr_d = addr_next(addr_q);
          end
          if (left_q == 9'd1) begin
            st_d = APW_DONE;
          end else if (blk_q == 9'd1) begin
            dly_d = 6'd0;
            st_d = APW_SETUP;
          end else begin
            // next sector of block, no wait
            word_d = 9'd0;
            bsy_d = 1'b0;
            drq_d = 1'b1;
            st_d = APW_XFER;
          end
        end
      end
      APW_DONE: begin
        cnt_d = left_q[7:0];
        bsy_d = 1'b0;
        drq_d = 1'b0;
        irq_d = 1'b1;
        st_d = APW_IDLE;
      end
      default: st_d = APW_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= APW_IDLE;
      addr_q <= {`APW_RST_SECNUM, `APW_RST_BYTE, `APW_RST_BYTE, `APW_RST_DRVHEAD};
      cnt_q <= `APW_RST_SECCNT;
      left_q <= 9'd0;
      blk_q <= 9'd0;
      word_q <= 9'd0;
      dly_q <= 6'd0;
      feat_q <= `APW_RST_BYTE;
      err_q <= `APW_RST_BYTE;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      errb_q <= 1'b0;
      irq_q <= 1'b0;
      multi_q <= 1'b0;
      erase_q <= 1'b1;
      wdata_q <= 16'h0000;
      wv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      blk_q <= blk_d;
      word_q <= word_d;
      dly_q <= dly_d;
      feat_q <= feat_d;
      err_q <= err_d;
      bsy_q <= bsy_d;
      drq_q <= drq_d;
      errb_q <= errb_d;
      irq_q <= irq_d;
      multi_q <= multi_d;
      erase_q <= erase_d;
      wdata_q <= wdata_d;
      wv_q <= wv_d;
    end
  end

  always_comb begin
    unique case (tf_addr)
      `APW_OFS_FEATURE: tf_rdata = err_q;
      `APW_OFS_SECCNT:  tf_rdata = cnt_q;
      `APW_OFS_SECNUM:  tf_rdata = addr_q.secnum;
      `APW_OFS_CYLLO:   tf_rdata = addr_q.cyllo;
      `APW_OFS_CYLHI:   tf_rdata = addr_q.cylhi;
      `APW_OFS_DRVHEAD: tf_rdata = addr_q.drvhead;
      `APW_OFS_CMD: begin
        tf_rdata = `APW_RST_BYTE;
        tf_rdata[`APW_ST_BSY] = bsy_q;
        tf_rdata[`APW_ST_DRDY] = !bsy_q;
        tf_rdata[`APW_ST_DSC] = !bsy_q;
        tf_rdata[`APW_ST_DRQ] = drq_q;
        tf_rdata[`APW_ST_ERR] = errb_q;
      end
      default: tf_rdata = `APW_RST_BYTE;
    endcase
  end

  assign media_req = '{valid: (st_q == APW_PROG), lba: lba_of(addr_q), erase: erase_q};
  assign media_wdata = wdata_q;
  assign media_wvalid = wv_q;
  assign intrq = irq_q;
endmodule
`default_nettype wire

// ---- src/apw_map.svh ----
// task-file offsets, field positions, reset values and timing counts
// assumes the includer works on a 100 MHz core clock
`ifndef APW_MAP_SVH
`define APW_MAP_SVH
`define APW_OFS_DATA        3'h0
`define APW_OFS_FEATURE     3'h1
`define APW_OFS_SECCNT      3'h2
`define APW_OFS_SECNUM      3'h3
`define APW_OFS_CYLLO       3'h4
`define APW_OFS_CYLHI       3'h5
`define APW_OFS_DRVHEAD     3'h6
`define APW_OFS_CMD         3'h7
`define APW_OP_WR_SEC       8'h30
`define APW_OP_WR_SEC_RT    8'h31
`define APW_OP_WR_SEC_NE    8'h38
`define APW_OP_WR_MUL       8'hC5
`define APW_OP_WR_MUL_NE    8'hCD
`define APW_ST_BSY          7
`define APW_ST_DRDY         6
`define APW_ST_DSC          4
`define APW_ST_DRQ          3
`define APW_ST_ERR          0
`define APW_ER_IDNF         4
`define APW_ER_ABRT         2
`define APW_DH_LBA          6
`define APW_BSY_NS          400
`define APW_CLK_NS          10
`define APW_BSY_CYC         (`APW_BSY_NS / `APW_CLK_NS)
`define APW_WORDS_PER_SEC   256
`define APW_RST_BYTE        8'h00
`define APW_RST_SECCNT      8'h01
`define APW_RST_SECNUM      8'h01
`define APW_RST_DRVHEAD     8'hA0
`endif

// ---- src/apw_pkg.sv ----
// types shared by the sector-write engine
// assumes apw_map.svh holds the numeric constants
package apw_pkg;
  typedef enum logic [2:0] {
    APW_IDLE  = 3'b000,
    APW_SETUP = 3'b001,
    APW_XFER  = 3'b010,
    APW_PROG  = 3'b011,
    APW_DONE  = 3'b100
  } apw_state_t;
  typedef struct packed {
    logic [7:0] secnum;
    logic [7:0] cyllo;
    logic [7:0] cylhi;
    logic [7:0] drvhead;
  } apw_addr_t;
  typedef struct packed {
    logic        valid;
    logic [27:0] lba;
    logic        erase;
  } apw_media_req_t;
endpackage

// ---- test/apw_engine_properties.sv ----
// port checker for the sector-write engine
// assumes bind onto apw_engine, single clock
`timescale 1ns/1ps
`default_nettype none
module apw_engine_properties #(parameter int unsigned MAX_BLOCK = 16) (
  input wire logic                    core_clk,
  input wire logic                    nrst,
  input wire logic                    tf_wr,
  input wire logic                    tf_rd,
  input wire logic [2:0]              tf_addr,
  input wire logic [15:0]             tf_wdata,
  input wire logic [7:0]              block_count,
  input wire logic                    multi_enable,
  input wire apw_pkg::apw_media_req_t media_req,
  input wire logic [15:0]             media_wdata,
  input wire logic                    media_wvalid,
  input wire logic                    intrq
);
  import apw_pkg::*;
  logic [7:0] op_q;
  wire logic  mcmd = tf_wr && tf_addr == 3'h7 && tf_wdata[7:0] inside {8'hC5, 8'hCD};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) op_q <= 8'h00;
    else if (tf_wr && tf_addr == 3'h7) op_q <= tf_wdata[7:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  intr_hold_a: assert property (intrq && !(tf_rd && tf_addr == 3'h7) |=> intrq)
    else $error("intrq dropped early");
  intr_clear_a: assert property (tf_rd && tf_addr == 3'h7 |=> !intrq)
    else $error("intrq not cleared");
  wvalid_src_a: assert property (media_wvalid |-> $past(tf_wr) && $past(tf_addr) == 3'h0)
    else $error("word without data write");
  wdata_copy_a: assert property (media_wvalid |-> media_wdata == $past(tf_wdata))
    else $error("word data differs");
  lba_hold_a: assert property (media_req.valid && $past(media_req.valid) |-> $stable(media_req.lba))
    else $error("lba moved while programming");
  erase_sel_a: assert property (media_req.valid |-> media_req.erase == !(op_q inside {8'h38, 8'hCD}))
    else $error("erase flag wrong");
  abort_intr_a: assert property (mcmd && (!multi_enable || block_count == 8'h00) |-> ##[1:3] intrq)
    else $error("no abort interrupt");
  intr_prog_a: assert property ($rose(intrq) |-> !media_req.valid)
    else $error("interrupt while programming");
endmodule
`default_nettype wire

// ---- test/apw_media_model.sv ----
// media stand-in: answers each programmed sector dly+1 cycles after the request
// assumes the engine holds media_req.valid until answered
`timescale 1ns/1ps
`default_nettype none
module apw_media_model (
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire apw_pkg::apw_media_req_t media_req,
  input  wire logic [7:0]              dly,
  input  wire logic [27:0]             fail_lba,
  output logic                         media_done,
  output logic                         media_fail
);
  import apw_pkg::*;
  logic [7:0] cnt_q;
  wire logic  hit = media_req.valid && cnt_q == dly;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q      <= 8'h00;
      media_done <= 1'b0;
      media_fail <= 1'b0;
    end else begin
      cnt_q      <= media_req.valid ? cnt_q + {7'h00, cnt_q != 8'hFF} : 8'h00;
      media_done <= hit && media_req.lba != fail_lba;
      media_fail <= hit && media_req.lba == fail_lba;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the sector-write engine
// assumes the media model answers every programmed sector
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apw_pkg::*;
  logic           core_clk = 1'b0, nrst = 1'b0, tf_wr = 1'b0, tf_rd = 1'b0, multi_enable = 1'b0;
  logic [2:0]     tf_addr = 3'h7;
  logic [15:0]    tf_wdata = 16'h0000, media_wdata;
  logic [7:0]     tf_rdata, block_count = 8'h00, dly = 8'h02, v;
  logic [27:0]    fail_lba = 28'hFFF_FFFF;
  logic           media_wvalid, media_done, media_fail, intrq;
  apw_media_req_t media_req;
  int             err_count = 0, cmp_count = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  apw_engine #(.MAX_BLOCK(16)) i_dut (.core_clk, .nrst, .tf_wr, .tf_rd, .tf_addr, .tf_wdata, .tf_rdata,
    .block_count, .multi_enable, .media_req, .media_wdata, .media_wvalid, .media_done, .media_fail, .intrq);
  apw_media_model i_media (.core_clk, .nrst, .media_req, .dly, .fail_lba, .media_done, .media_fail);
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    tf_wr <= 1'b1; tf_addr <= a; tf_wdata <= d;
    @(posedge core_clk);
    tf_wr <= 1'b0; tf_addr <= 3'h7;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] q);
    @(posedge core_clk);
    tf_rd <= 1'b1; tf_addr <= a;
    #1 q = tf_rdata;
    @(posedge core_clk);
    tf_rd <= 1'b0; tf_addr <= 3'h7;
  endtask
  task automatic wait_st(input logic [7:0] m, e, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge core_clk);
      #1;
      if ((tf_rdata & m) === e) break;
    end
    chk("status", e, tf_rdata & m);
  endtask
  task automatic run_cmd(input logic [7:0] op, input int n, bc, fi, input logic ers);
    wr(3'h6, 16'h0043); wr(3'h5, 16'h0012); wr(3'h4, 16'h0034); wr(3'h3, 16'h00FE);
    wr(3'h2, n[15:0]);
    wr(3'h7, {8'h00, op});
    wait_st(8'h80, 8'h80, 40);
    for (int i = 0; i < n; i++) begin
      wait_st(8'h88, 8'h08, 200);
      #10 chk("intrq", i > 0 && i % bc == 0, intrq);
      rd(3'h7, v);
      for (int w = 0; w < 256; w++) wr(3'h0, 16'hA500 ^ w[15:0]);
      wait_st(8'h88, 8'h80, 10);
      chk("lba", 28'h312_34FE + i, media_req.lba);
      chk("erase", ers, media_req.erase);
      if (i == fi) break;
    end
    wait_st(8'h89, fi < n ? 8'h01 : 8'h00, 200);
    chk("intrq", 1'b1, intrq);
    rd(3'h7, v);
  endtask
  task automatic t_single;
    run_cmd(8'h30, 2, 1, 99, 1'b1);
    rd(3'h3, v); chk("secnum", 8'hFF, v);
    run_cmd(8'h31, 1, 1, 99, 1'b1);
    run_cmd(8'h38, 1, 1, 99, 1'b0);
    $display("test single done");
  endtask
  task automatic t_multi;
    block_count <= 8'h02; multi_enable <= 1'b1; dly <= 8'h1E;
    run_cmd(8'hCD, 3, 2, 99, 1'b0);
    rd(3'h4, v); chk("cyllo", 8'h35, v);
    dly <= 8'h02;
    $display("test multi done");
  endtask
  task automatic t_fail;
    block_count <= 8'h04; fail_lba <= 28'h312_3500;
    run_cmd(8'hC5, 8, 4, 2, 1'b1);
    rd(3'h1, v); chk("error", 8'h10, v);
    rd(3'h2, v); chk("count", 8'h06, v);
    rd(3'h3, v); chk("secnum", 8'h00, v);
    fail_lba <= 28'hFFF_FFFF;
    $display("test fail done");
  endtask
  task automatic t_abort;
    for (int j = 0; j < 2; j++) begin
      multi_enable <= j[0]; block_count <= j ? 8'h00 : 8'h02;
      wr(3'h7, j ? 16'h00CD : 16'h00C5);
      wait_st(8'h81, 8'h01, 10);
      rd(3'h1, v); chk("error", 8'h04, v);
      rd(3'h7, v);
    end
    $display("test abort done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_single();
    t_multi();
    t_fail();
    t_abort();
    stop_test();
  end
endmodule
bind apw_engine apw_engine_properties #(.MAX_BLOCK(MAX_BLOCK)) i_prop (.core_clk, .nrst, .tf_wr, .tf_rd,
  .tf_addr, .tf_wdata, .block_count, .multi_enable, .media_req, .media_wdata, .media_wvalid, .intrq);
`default_nettype wire
